// [test/dtr_host_model.sv]
// processor-side model: processor clock ticks and the family strap
// assumes the same sys_clk and synchronous rst as the register bank
`timescale 1ns/10ps
module dtr_host_model #(
	parameter logic FAMILY = 1'b1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// processor side
	output logic proc_clk_tick,
	output logic processor_family_pin
);
	// strap is static, so sampling at any power-up point gives one answer
	assign processor_family_pin = FAMILY;
	// one tick every other cycle, processor running at half the bus rate
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			proc_clk_tick <= 1'b0;
		end else begin
			proc_clk_tick <= !proc_clk_tick;
		end
	end
endmodule

// [test/dtr_regs_monitor.sv]
// port-level checks for the diagnostic and test register bank
// assumes clk_en stays high and a single sys_clk domain
`timescale 1ns/10ps
module dtr_regs_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// pins and bus
	input wire logic power_on_reset_in,
	input wire logic master_n,
	input wire logic memr_n,
	input wire logic memw_n,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic [15:0] io_wdata,
	input wire logic power_down,
	input wire logic edge_level_select,
	input wire logic kbd_gate,
	// outputs
	input wire logic outputs_float,
	input wire logic master_refresh_support,
	input wire logic gate_a20,
	input wire logic alternate_gate_control,
	input wire logic power_control_io6,
	input wire logic clock_switch_reset,
	input wire logic pulldowns_on,
	input wire logic irq_level_mode
);
	wire logic all_held = !master_n && !memr_n && !memw_n;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_float_on;
		$rose(outputs_float) |-> $past(power_on_reset_in, 3) && $past(all_held, 3);
	endproperty
	a_float_on: assert property (p_float_on)
		else $error("float entered without reset and strobes");
	property p_float_off;
		$fell(outputs_float) |-> $past(power_on_reset_in, 3) && !$past(all_held, 3);
	endproperty
	a_float_off: assert property (p_float_off)
		else $error("float left without reset");
	property p_refmas;
		io_wr && io_addr == 16'h9872 |=> master_refresh_support == $past(io_wdata[11]);
	endproperty
	a_refmas: assert property (p_refmas)
		else $error("refresh support not taken from write");
	property p_gate_pin;
		power_control_io6 == gate_a20 && gate_a20 ==
			($past(alternate_gate_control) || $past(kbd_gate));
	endproperty
	a_gate_pin: assert property (p_gate_pin)
		else $error("power control pin differs from gate");
	property p_csw_min;
		$rose(clock_switch_reset) |-> clock_switch_reset[*8] ##17 clock_switch_reset;
	endproperty
	a_csw_min: assert property (p_csw_min)
		else $error("clock switch pulse too short");
	property p_csw_end;
		$rose(clock_switch_reset) |-> ##[25:200] !clock_switch_reset;
	endproperty
	a_csw_end: assert property (p_csw_end)
		else $error("clock switch pulse too long");
	property p_pld; pulldowns_on |-> $past(power_down); endproperty
	a_pld: assert property (p_pld)
		else $error("pulldowns outside power down");
	property p_lvl; irq_level_mode |-> $past(edge_level_select); endproperty
	a_lvl: assert property (p_lvl)
		else $error("level mode without select bit");
endmodule
bind dtr_regs dtr_regs_monitor MON (.sys_clk, .rst, .power_on_reset_in,
	.master_n, .memr_n, .memw_n, .io_addr, .io_wr, .io_wdata, .power_down,
	.edge_level_select, .outputs_float, .master_refresh_support, .gate_a20,
	.power_control_io6, .clock_switch_reset, .pulldowns_on, .irq_level_mode,
	.kbd_gate, .alternate_gate_control);

// [test/dtr_regs_test.sv]
// self-checking bench for the diagnostic and test register bank
// assumes the processor-side model and the bound port monitor
`timescale 1ns/10ps
module dtr_regs_test;
	localparam logic [2:0] REV = 3'h2; // arbitrary value
	localparam logic [3:0] SREV = 4'h6; // arbitrary value
	logic sys_clk = 1'b0, rst = 1'b1, power_on_reset_in = 1'b1;
	logic master_n = 1'b1, memr_n = 1'b1, memw_n = 1'b1;
	logic io_wr = 1'b0, io_rd = 1'b0, kbd_gate = 1'b0, speaker_in = 1'b1;
	logic kbd_output_port_read = 1'b0, refresh_cycle = 1'b0;
	logic clock_switch_req = 1'b0, power_down = 1'b1, page_hit = 1'b1;
	logic edge_level_select = 1'b1;
	logic [15:0] io_addr = 16'h0000, io_wdata = 16'h0000, io_rdata;
	logic [7:0] kbd_port_data = 8'hA5, kbd_port_rdata;
	logic proc_clk_tick, processor_family_pin, outputs_float, gate_a20;
	logic alternate_gate_control, power_control_io6, master_refresh_support;
	logic clock_switch_reset, speaker_out, test_signal_select_out, pulldowns_on;
	logic first_access_page, irq_level_mode;
	logic [5:0] buffer_strength;
	int fails = 0, cmp_count = 0;
	dtr_host_model HOST (.sys_clk, .rst, .proc_clk_tick, .processor_family_pin);
	dtr_regs #(.MASK_REV(REV), .SEC_REV(SREV), .LONG_CYC(16'h0032)) DUT (
		.sys_clk, .rst, .clk_en(1'b1), .power_on_reset_in, .master_n,
		.memr_n, .memw_n, .processor_family_pin, .io_addr, .io_wr, .io_rd,
		.io_wdata, .io_rdata, .kbd_gate, .kbd_output_port_read,
		.kbd_port_data, .kbd_port_rdata, .test_signals(64'h20),
		.speaker_in, .refresh_cycle, .delay_tap_early(1'b1), .proc_clk_tick,
		.clock_switch_req, .power_down, .page_hit, .edge_level_select,
		.outputs_float, .gate_a20, .alternate_gate_control,
		.power_control_io6, .master_refresh_support, .clock_switch_reset,
		.speaker_out, .test_signal_select_out, .buffer_strength, .pulldowns_on,
		.first_access_page, .irq_level_mode);
	task automatic close_out();
		if (fails == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [15:0] a, d);
		@(posedge sys_clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge sys_clk);
		io_wr <= 1'b0;
	endtask
	// read data stands one cycle; taken mid-cycle while it stands
	task automatic rd(input logic [15:0] a, exp, input string nm);
		@(posedge sys_clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge sys_clk);
		io_rd <= 1'b0;
		@(negedge sys_clk);
		chk(nm, io_rdata, exp);
	endtask
	task automatic csw(input logic [15:0] lo, hi, input string nm);
		int w = 0;
		@(posedge sys_clk);
		clock_switch_req <= 1'b1;
		@(posedge sys_clk);
		clock_switch_req <= 1'b0;
		repeat (150) begin
			@(posedge sys_clk);
			w += clock_switch_reset;
		end
		chk(nm, 16'(w >= lo && w <= hi), 16'h0001);
	endtask
	initial forever #20 sys_clk = ~sys_clk;
	initial begin
		repeat (4000) @(posedge sys_clk);
		fails++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		// strap is sampled only while the power-on pin is still up
		repeat (4) @(posedge sys_clk);
		power_on_reset_in <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rd(16'h9872, {REV, 5'h00, 1'b1, 1'b0, 6'h00}, "test_signal_select");
		rd(16'hA872, {SREV, 12'h000}, "test");
		wr(16'h1234, 16'hFFFF);
		rd(16'h1234, 16'h0000, "unmapped");
		wr(16'h9872, 16'hFF45);
		rd(16'h9872, {REV, 5'h0D, 1'b1, 1'b1, 6'h05}, "test_signal_select");
		chk("refmas", master_refresh_support, 16'h0001);
		chk("speaker", speaker_out, 16'h0001);
		chk("test_signal_select out", test_signal_select_out, 16'h0000);
		for (int s = 0; s < 2; s++) begin
			wr(16'h9872, 16'(s));
			repeat (2) @(posedge sys_clk);
			chk("speaker", speaker_out, 16'(s == 0));
		end
		for (int a = 0; a < 2; a++) begin
			wr(16'h9872, a ? 16'h0400 : 16'h0000);
			for (int g = 0; g < 2; g++) begin
				kbd_gate <= g[0];
				kbd_output_port_read <= g[0];
				repeat (4) @(posedge sys_clk);
				chk("gate", gate_a20, 16'(g));
				chk("pin6", power_control_io6, 16'(g));
				chk("alt", alternate_gate_control, 16'(a & g));
				chk("kbd", kbd_port_rdata, g ? {6'h29, a[0], 1'b1} : 8'hA5);
			end
		end
		repeat (3) begin
			@(posedge sys_clk);
			refresh_cycle <= 1'b1;
			@(posedge sys_clk);
			refresh_cycle <= 1'b0;
		end
		rd(16'hA072, 16'h0003, "delay");
		chk("strength", buffer_strength, 16'h0003);
		wr(16'hA072, 16'h006A);
		rd(16'hA072, 16'h0043, "delay");
		wr(16'hA072, 16'h006A);
		rd(16'hA072, 16'h006A, "delay");
		chk("strength", buffer_strength, 16'h002A);
		wr(16'hA072, 16'h00D5);
		rd(16'hA072, 16'h00D5, "delay");
		chk("strength", buffer_strength, 16'h002A);
		for (int v = 0; v < 2; v++) begin
			wr(16'hA872, v ? 16'hFFFF : 16'h0000);
			rd(16'hA872, {SREV, 2'b00, v ? 10'h3FF : 10'h000}, "test");
			chk("pulldown", pulldowns_on, 16'(v));
			chk("page", first_access_page, 16'(1 - v));
			chk("level", irq_level_mode, 16'(v));
		end
		csw(16'h0037, 16'h003C, "short");
		wr(16'h9872, 16'h0100);
		csw(16'h0031, 16'h0033, "long");
		power_on_reset_in <= 1'b1;
		{master_n, memr_n, memw_n} <= 3'b000;
		repeat (6) @(posedge sys_clk);
		chk("float on", outputs_float, 16'h0001);
		power_on_reset_in <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk("float hold", outputs_float, 16'h0001);
		power_on_reset_in <= 1'b1;
		memr_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk("float off", outputs_float, 16'h0000);
		close_out();
	end
endmodule

// [verilog/dtr_defines.svh]
// offsets, field positions, reset values and timing counts for the
// diagnostic and test register bank; included by the design files
`ifndef DTR_DEFINES_SVH
`define DTR_DEFINES_SVH
`define DTR_OFS_TEST_SIGNAL_SELECT 16'h9872
`define DTR_OFS_DELAY 16'hA072
`define DTR_OFS_TEST 16'hA872
`define DTR_BIT_REFMAS 11
`define DTR_BIT_AUTO 10
`define DTR_BIT_UNUSED 9
`define DTR_BIT_CLKSW 8
`define DTR_BIT_FAMILY 7
`define DTR_BIT_LEVEL 6
`define DTR_BIT_HOLD 7
`define DTR_BIT_FREEZE 6
`define DTR_BIT_PLD 2
`define DTR_BIT_FIRST_ACCESS_PAGE_INHIBIT 1
`define DTR_BIT_LVL 0
`define DTR_TEST_RW_MASK 16'h03FF
`define DTR_RST_TEST_SIGNAL_SELECT_CTL 6'h00
`define DTR_RST_DELAY 6'h00
`define DTR_SEL_NORMAL 6'h00
`define DTR_SEL_SPK_OFF 6'h01
`define DTR_EXTENDED_REV 3'h7
// clock rate and pulse times
`define DTR_CLK_HZ 25000000
`define DTR_SHORT_US 1
`define DTR_LONG_MS 1
`define DTR_PROC_CLKS 16
`define DTR_SHORT_CYC ((`DTR_CLK_HZ / 1000000) * `DTR_SHORT_US)
`define DTR_LONG_CYC ((`DTR_CLK_HZ / 1000) * `DTR_LONG_MS)
`endif

// [verilog/dtr_pkg.sv]
// types shared by the diagnostic and test register bank
// assumes dtr_defines.svh supplies the numeric constants
package dtr_pkg;
	typedef enum logic [1:0] {
		DTR_PW_IDLE,
		DTR_PW_TIME,
		DTR_PW_PROC
	} dtr_pw_state_t;
endpackage

// [verilog/dtr_regs.sv]
// diagnostic register, delay line diagnostic and test enable registers,
// plus the all-outputs-tristate mode
// assumes a synchronous I/O port bus on sys_clk; pins from outside are
// synchronised here
`timescale 1ns/10ps
`include "dtr_defines.svh"
// Function
// RL1 - bus master and both strobes held in reset float every output
// RL2 - float persists after reset release while all three stay held
// RL3 - reset with any of the three released restores output drive
// RL4 - top three bits return mask revision; seven means read extended fields
// RL5 - bit 11 enables bus master refresh support, reset zero
// RL6 - without auto tracking, gate is alternate control OR keyboard gate
// RL7 - with auto tracking, alternate gate bit follows keyboard gate
// RL8 - output-port read data substitutes auto tracking bit for gate status
// RL9 - gate state appears as power-control output six
// RL10 - clock switch pulse 1 us plus 16 processor clocks, or 1 ms
// RL11 - processor family sampled at power up, read-only bit 7
// RL12 - bit 6 shows selected test signal; 0 normal, 1 speaker off
// RL13 - bit 9 has no function; writes ignored
// RL14 - strength follows delay count unless strength hold set
// RL15 - delay line steps one element per refresh cycle normally
// RL16 - freeze stops calibration; delay count writable only while frozen
// RL17 - delay count sets output buffer strength
// RL18 - test enable upper six read-only, lower ten writable, reset clear
// RL19 - pulldown enable acts during processor or full power down
// RL20 - first access page inhibit forces page miss cycles
// RL21 - level trigger permit gates the edge or level select bit
// RL22 - reserved select codes behave like normal speaker operation
module dtr_regs
	import dtr_pkg::*;
#(
	parameter logic [2:0] MASK_REV = 3'h1, // arbitrary value
	parameter logic [3:0] SEC_REV = 4'h5, // arbitrary value
	parameter logic [15:0] LONG_CYC = 16'(`DTR_LONG_CYC)
) (
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	// pins sampled from outside
	input wire logic power_on_reset_in,
	input wire logic master_n,
	input wire logic memr_n,
	input wire logic memw_n,
	input wire logic processor_family_pin,
	// I/O port register access
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [15:0] io_wdata,
	output logic [15:0] io_rdata,
	// system hooks
	input wire logic kbd_gate,
	input wire logic kbd_output_port_read,
	input wire logic [7:0] kbd_port_data,
	output logic [7:0] kbd_port_rdata,
	input wire logic [63:0] test_signals,
	input wire logic speaker_in,
	input wire logic refresh_cycle,
	input wire logic delay_tap_early,
	input wire logic proc_clk_tick,
	input wire logic clock_switch_req,
	input wire logic power_down,
	input wire logic page_hit,
	input wire logic edge_level_select,
	output logic outputs_float,
	output logic gate_a20,
	output logic alternate_gate_control,
	output logic power_control_io6,
	output logic master_refresh_support,
	output logic clock_switch_reset,
	output logic speaker_out,
	output logic test_signal_select_out,
	output logic [5:0] buffer_strength,
	output logic pulldowns_on,
	output logic first_access_page,
	output logic irq_level_mode
);
	// pin synchronisers: first stage feeds only the second
	logic [4:0] sync1_ff, sync2_ff;
	logic por_s, master_s, memr_s, memw_s, family_s;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1_ff <= 5'h00;
			sync2_ff <= 5'h00;
		end else if (clk_en) begin
			sync1_ff <= {power_on_reset_in, ~master_n, ~memr_n, ~memw_n,
				processor_family_pin};
			sync2_ff <= sync1_ff;
		end
	end
	assign {por_s, master_s, memr_s, memw_s, family_s} = sync2_ff;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
		hit = (a == o);
	endfunction

	// diagnostic word built by field position; bits 12 and 9 read 0
	function automatic logic [15:0] test_signal_select_word(input logic refmas,
		input logic auto_trk, input logic clksw, input logic family,
		input logic level, input logic [5:0] sel);
		logic [15:0] w;
		w = 16'h0000;
		w[15:13] = MASK_REV;
		w[`DTR_BIT_REFMAS] = refmas;
		w[`DTR_BIT_AUTO] = auto_trk;
		w[`DTR_BIT_UNUSED] = 1'b0;
		w[`DTR_BIT_CLKSW] = clksw;
		w[`DTR_BIT_FAMILY] = family;
		w[`DTR_BIT_LEVEL] = level;
		w[5:0] = sel;
		test_signal_select_word = w;
	endfunction

	// delay word: upper byte has no storage and reads 0
	function automatic logic [15:0] delay_word(input logic hold,
		input logic freeze, input logic [5:0] count);
		logic [15:0] w;
		w = 16'h0000;
		w[`DTR_BIT_HOLD] = hold;
		w[`DTR_BIT_FREEZE] = freeze;
		w[5:0] = count;
		delay_word = w;
	endfunction

	// register state
	logic float_ff, nxt_float;
	logic family_ff, nxt_family;
	logic refmas_ff, nxt_refmas;
	logic auto_ff, nxt_auto;
	logic clksw_ff, nxt_clksw;
	logic [5:0] sel_ff, nxt_sel;
	logic hold_ff, nxt_hold;
	logic freeze_ff, nxt_freeze;
	logic [5:0] delay_ff, nxt_delay;
	logic [5:0] strength_ff, nxt_strength;
	logic [9:0] test_ff, nxt_test;
	logic altg_ff, nxt_altg;
	logic [15:0] rdata_ff, nxt_rdata;
	logic [7:0] kbd_ff, nxt_kbd;
	logic gate_ff, nxt_gate;
	logic level_ff, nxt_level;
	logic spk_ff, nxt_spk;
	logic test_signal_select_ff, nxt_test_signal_select;
	logic pld_ff, nxt_pld;
	logic fap_ff, nxt_fap;
	logic irq_ff, nxt_irq;
	logic wr_test_signal_select, wr_delay, wr_test, pulse;
	logic gate_now, sel_level;

	assign wr_test_signal_select = io_wr && hit(io_addr, `DTR_OFS_TEST_SIGNAL_SELECT);
	assign wr_delay = io_wr && hit(io_addr, `DTR_OFS_DELAY);
	assign wr_test = io_wr && hit(io_addr, `DTR_OFS_TEST);

	always_comb begin
		nxt_float = float_ff;
		if (por_s) begin
			nxt_float = master_s && memr_s && memw_s; // RL1 RL3
		end
		// outside reset the mode stays; release of a strobe does not end it
		// RL2
		nxt_family = family_ff;
		if (por_s) begin
			nxt_family = family_s; // RL11
		end
		nxt_refmas = refmas_ff;
		nxt_auto = auto_ff;
		nxt_clksw = clksw_ff;
		nxt_sel = sel_ff;
		if (wr_test_signal_select) begin
			nxt_refmas = io_wdata[`DTR_BIT_REFMAS]; // RL5
			nxt_auto = io_wdata[`DTR_BIT_AUTO];
			nxt_clksw = io_wdata[`DTR_BIT_CLKSW];
			nxt_sel = io_wdata[5:0]; // RL13
		end
		nxt_hold = hold_ff;
		nxt_freeze = freeze_ff;
		nxt_delay = delay_ff;
		if (!freeze_ff && refresh_cycle) begin
			// self-tuning: one element per refresh toward the early tap
			if (delay_tap_early && delay_ff != 6'h3F) begin
				nxt_delay = delay_ff + 6'h01; // RL15
			end else if (!delay_tap_early && delay_ff != 6'h00) begin
				nxt_delay = delay_ff - 6'h01; // RL15
			end
		end
		if (wr_delay) begin
			nxt_hold = io_wdata[`DTR_BIT_HOLD];
			nxt_freeze = io_wdata[`DTR_BIT_FREEZE];
			if (freeze_ff) begin
				nxt_delay = io_wdata[5:0]; // RL16
			end
		end
		nxt_strength = hold_ff ? strength_ff : delay_ff; // RL14 RL17
		nxt_test = test_ff;
		if (wr_test) begin
			nxt_test = 10'(io_wdata & `DTR_TEST_RW_MASK); // RL18
		end
		nxt_altg = altg_ff;
		if (auto_ff) begin
			nxt_altg = kbd_gate; // RL7
		end
		gate_now = altg_ff | kbd_gate; // RL6
		nxt_gate = gate_now;
		sel_level = test_signals[sel_ff];
		nxt_level = sel_level; // RL12
		nxt_spk = speaker_in;
		nxt_test_signal_select = 1'b0;
		case (sel_ff)
			`DTR_SEL_NORMAL: nxt_spk = speaker_in; // RL12
			`DTR_SEL_SPK_OFF: nxt_spk = 1'b0; // RL12
			// reserved codes leave the system untouched
			default: nxt_spk = speaker_in; // RL22
		endcase
		nxt_pld = test_ff[`DTR_BIT_PLD] && power_down; // RL19
		nxt_fap = page_hit && !test_ff[`DTR_BIT_FIRST_ACCESS_PAGE_INHIBIT]; // RL20
		nxt_irq = test_ff[`DTR_BIT_LVL] && edge_level_select; // RL21
		nxt_kbd = kbd_port_data;
		if (kbd_output_port_read) begin
			nxt_kbd[1] = auto_ff; // RL8
		end
		nxt_rdata = 16'h0000;
		if (io_rd) begin
			if (hit(io_addr, `DTR_OFS_TEST_SIGNAL_SELECT)) begin
				nxt_rdata = test_signal_select_word(refmas_ff, auto_ff, clksw_ff,
					family_ff, level_ff, sel_ff); // RL4
			end else if (hit(io_addr, `DTR_OFS_DELAY)) begin
				nxt_rdata = delay_word(hold_ff, freeze_ff, delay_ff);
			end else if (hit(io_addr, `DTR_OFS_TEST)) begin
				nxt_rdata = {SEC_REV, 2'b00, test_ff}; // RL4 RL18
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			float_ff <= 1'b0;
			family_ff <= 1'b0;
			refmas_ff <= 1'b0;
			auto_ff <= 1'b0;
			clksw_ff <= 1'b0;
			sel_ff <= `DTR_RST_TEST_SIGNAL_SELECT_CTL;
			hold_ff <= 1'b0;
			freeze_ff <= 1'b0;
			delay_ff <= `DTR_RST_DELAY;
			strength_ff <= `DTR_RST_DELAY;
			test_ff <= 10'h000;
			altg_ff <= 1'b0;
			rdata_ff <= 16'h0000;
			kbd_ff <= 8'h00;
			gate_ff <= 1'b0;
			level_ff <= 1'b0;
			spk_ff <= 1'b0;
			test_signal_select_ff <= 1'b0;
			pld_ff <= 1'b0;
			fap_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else if (clk_en) begin
			float_ff <= nxt_float;
			family_ff <= nxt_family;
			refmas_ff <= nxt_refmas;
			auto_ff <= nxt_auto;
			clksw_ff <= nxt_clksw;
			sel_ff <= nxt_sel;
			hold_ff <= nxt_hold;
			freeze_ff <= nxt_freeze;
			delay_ff <= nxt_delay;
			strength_ff <= nxt_strength;
			test_ff <= nxt_test;
			altg_ff <= nxt_altg;
			rdata_ff <= nxt_rdata;
			kbd_ff <= nxt_kbd;
			gate_ff <= nxt_gate;
			level_ff <= nxt_level;
			spk_ff <= nxt_spk;
			test_signal_select_ff <= nxt_test_signal_select;
			pld_ff <= nxt_pld;
			fap_ff <= nxt_fap;
			irq_ff <= nxt_irq;
		end
	end

	dtr_sw_pulse #(
		.LONG_CYC(LONG_CYC)
	) u_pulse (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.start(clock_switch_req),
		.long_width(clksw_ff), // RL10
		.proc_clk_tick(proc_clk_tick),
		.pulse_out(pulse)
	);

	assign outputs_float = float_ff;
	assign gate_a20 = gate_ff;
	assign power_control_io6 = gate_ff; // RL9
	assign alternate_gate_control = altg_ff;
	assign master_refresh_support = refmas_ff;
	assign clock_switch_reset = pulse;
	assign speaker_out = spk_ff;
	assign test_signal_select_out = test_signal_select_ff;
	assign buffer_strength = strength_ff;
	assign pulldowns_on = pld_ff;
	assign first_access_page = fap_ff;
	assign irq_level_mode = irq_ff;
	assign io_rdata = rdata_ff;
	assign kbd_port_rdata = kbd_ff;
endmodule

// [verilog/dtr_sw_pulse.sv]
// clock-switch reset pulse generator
// assumes proc_clk_tick is a one-cycle pulse per processor clock, same domain
`timescale 1ns/10ps
`include "dtr_defines.svh"
module dtr_sw_pulse
	import dtr_pkg::*;
#(
	parameter logic [15:0] LONG_CYC = 16'(`DTR_LONG_CYC)
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	// control
	input wire logic start,
	input wire logic long_width,
	input wire logic proc_clk_tick,
	// pulse
	output logic pulse_out
);
	dtr_pw_state_t state_ff, nxt_state;
	logic [15:0] cnt_ff, nxt_cnt;
	logic pulse_ff, nxt_pulse;

	assign pulse_out = pulse_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_pulse = pulse_ff;
		case (state_ff)
			DTR_PW_IDLE: begin
				if (start) begin
					nxt_state = DTR_PW_TIME;
					nxt_pulse = 1'b1;
					nxt_cnt = long_width ? LONG_CYC - 16'h0001 :
						16'(`DTR_SHORT_CYC) - 16'h0001;
				end
			end
			DTR_PW_TIME: begin
				if (cnt_ff != 16'h0000) begin
					nxt_cnt = cnt_ff - 16'h0001;
				end else if (long_width) begin
					nxt_state = DTR_PW_IDLE;
					nxt_pulse = 1'b0;
				end else begin
					// short width adds processor clocks after the fixed time
					nxt_state = DTR_PW_PROC;
					nxt_cnt = 16'(`DTR_PROC_CLKS);
				end
			end
			DTR_PW_PROC: begin
				if (proc_clk_tick) begin
					nxt_cnt = cnt_ff - 16'h0001;
					if (cnt_ff == 16'h0001) begin
						nxt_state = DTR_PW_IDLE;
						nxt_pulse = 1'b0;
					end
				end
			end
			default: begin
				nxt_state = DTR_PW_IDLE;
				nxt_pulse = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_ff <= DTR_PW_IDLE;
			cnt_ff <= 16'h0000;
			pulse_ff <= 1'b0;
		end else if (clk_en) begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			pulse_ff <= nxt_pulse;
		end
	end
endmodule
